// ===== osp_pkg.sv
// constants for the output synchronisation parameter block
package osp_pkg;
   // clock and time base
   localparam int unsigned  CLK_FREQ_HZ   = 10_000_000;
   localparam logic [31:0]  CLK_PERIOD_NS = 32'(1_000_000_000 / CLK_FREQ_HZ);
   localparam logic [31:0]  NS_MAX        = 32'hFFFFFFFF;

   // register indices on the plain register port
   localparam logic [7:0]   IDX_ENTRY_COUNT  = 8'h00;
   localparam logic [7:0]   IDX_SYNC_MODE    = 8'h01;
   localparam logic [7:0]   IDX_CYCLE_PERIOD = 8'h02;
   localparam logic [7:0]   IDX_SYNC0_DELAY  = 8'h03;
   localparam logic [7:0]   IDX_SUPPORTED    = 8'h04;
   localparam logic [7:0]   IDX_MIN_CYCLE    = 8'h05;
   localparam logic [7:0]   IDX_MIN_GAP      = 8'h06;
   localparam logic [7:0]   IDX_MIN_DELAY    = 8'h07;
   localparam logic [7:0]   IDX_COMMAND      = 8'h08;
   localparam logic [7:0]   IDX_SYNC1_DELAY  = 8'h09;
   localparam logic [7:0]   IDX_MISSED       = 8'h0B;
   localparam logic [7:0]   IDX_OVERRUN      = 8'h0C;
   localparam logic [7:0]   IDX_SHORT        = 8'h0D;
   localparam logic [7:0]   IDX_LATE         = 8'h20;

   // reset and constant values
   localparam logic [7:0]   ENTRY_COUNT_VAL  = 8'h20;
   localparam logic [15:0]  SYNC_MODE_RST    = 16'h0001;
   localparam logic [31:0]  CYCLE_PERIOD_RST = 32'h000F4240;
   localparam logic [31:0]  SYNC0_DELAY_RST  = 32'h00000384;
   localparam logic [15:0]  SUPPORTED_VAL    = 16'h8002;
   localparam logic [31:0]  MIN_CYCLE_RST    = 32'h00002710;
   localparam logic [31:0]  MIN_GAP_RST      = 32'h00000000;
   localparam logic [31:0]  MIN_DELAY_VAL    = 32'h00000384;
   localparam logic [15:0]  COMMAND_RST      = 16'h0000;
   localparam logic [31:0]  SYNC1_DELAY_RST  = 32'h00000384;
   localparam logic [15:0]  COUNT_RST        = 16'h0000;

   // sync mode and command codes
   localparam logic [15:0]  MODE_FREE_RUN    = 16'h0000;
   localparam logic [15:0]  MODE_SM_SYNC     = 16'h0001;
   localparam logic [15:0]  CMD_START        = 16'h0001;

   // pin vector positions and event counter slots
   localparam int           PIN_SM2  = 0;
   localparam int           PIN_S0   = 1;
   localparam int           PIN_S1   = 2;
   localparam int           PIN_DONE = 3;
   localparam int           PIN_DC   = 4;
   localparam int           PIN_OP   = 5;
   localparam int           PIN_NUM  = 6;
   localparam int           CNT_MISSED  = 0;
   localparam int           CNT_OVERRUN = 1;
   localparam int           CNT_SHORT   = 2;
   localparam int           CNT_NUM     = 3;
   localparam int           CNT_W       = 16;
endpackage

// ===== osp_sat_cnt.sv
// saturating event counter
`timescale 1ns/1ps
module osp_sat_cnt #(
   parameter int W = 16
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         inc_in,
   output logic [W-1:0]      count_out
);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_out <= '0;
      end else if (inc_in && (count_out != {W{1'b1}})) begin
         count_out <= count_out + 1'b1;
      end
   end
endmodule // osp_sat_cnt

// ===== osp_sync_monitor.sv
// output synchronisation parameter set, timing monitor and register port
`timescale 1ns/1ps
module osp_sync_monitor (
   input  wire logic          CLK_IN,
   input  wire logic          RST_N_IN,
   input  wire logic [7:0]    ADDR_IN,
   input  wire logic [31:0]   WR_DATA_IN,
   input  wire logic          WR_IN,
   input  wire logic          RD_IN,
   output logic      [31:0]   RD_DATA_OUT,
   input  wire logic          SM2_EVENT_IN,
   input  wire logic          SYNC0_IN,
   input  wire logic          SYNC1_IN,
   input  wire logic          OUT_DONE_IN,
   input  wire logic          DC_MODE_IN,
   input  wire logic          OPERATIONAL_IN,
   output logic               CYCLE_START_OUT,
   output logic               MEASURING_OUT
);
   localparam logic [31:0] CLK_NS = osp_pkg::CLK_PERIOD_NS;

   function automatic logic [31:0] sat_add(input logic [31:0] a);
      if (a > (osp_pkg::NS_MAX - CLK_NS)) begin
         return osp_pkg::NS_MAX;
      end
      return a + CLK_NS;
   endfunction

   function automatic logic [31:0] max32(input logic [31:0] a,
                                         input logic [31:0] b);
      return (a > b) ? a : b;
   endfunction

   // pin synchronisers and edge detection
   logic [osp_pkg::PIN_NUM-1:0] pin_meta;
   logic [osp_pkg::PIN_NUM-1:0] pin_sync;
   logic [osp_pkg::PIN_NUM-1:0] pin_prev;
   logic [osp_pkg::PIN_NUM-1:0] pin_rise;
   logic [osp_pkg::PIN_NUM-1:0] pin_raw;

   assign pin_raw = {OPERATIONAL_IN, DC_MODE_IN, OUT_DONE_IN,
                     SYNC1_IN, SYNC0_IN, SM2_EVENT_IN};

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign pin_rise = pin_sync & ~pin_prev;

   logic ev_sm2;
   logic ev_s0;
   logic ev_s1;
   logic ev_done;
   logic dc_mode;
   logic op_state;

   assign ev_sm2   = pin_rise[osp_pkg::PIN_SM2];
   assign ev_s0    = pin_rise[osp_pkg::PIN_S0];
   assign ev_s1    = pin_rise[osp_pkg::PIN_S1];
   assign ev_done  = pin_rise[osp_pkg::PIN_DONE];
   assign dc_mode  = pin_sync[osp_pkg::PIN_DC];
   assign op_state = pin_sync[osp_pkg::PIN_OP];

   // register write decode
   logic [15:0] sync_mode;
   logic [31:0] cycle_period;
   logic [15:0] command;
   logic        measuring;
   logic        wr_mode;
   logic        wr_cycle;
   logic        wr_cmd;
   logic        meas_start;

   assign wr_mode    = WR_IN && (ADDR_IN == osp_pkg::IDX_SYNC_MODE);
   assign wr_cycle   = WR_IN && (ADDR_IN == osp_pkg::IDX_CYCLE_PERIOD);
   assign wr_cmd     = WR_IN && (ADDR_IN == osp_pkg::IDX_COMMAND);
   assign measuring  = (command == osp_pkg::CMD_START);
   assign meas_start = wr_cmd && !measuring &&
                       (WR_DATA_IN[15:0] == osp_pkg::CMD_START);

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sync_mode <= osp_pkg::SYNC_MODE_RST;
      end else if (wr_mode) begin
         sync_mode <= WR_DATA_IN[15:0];
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cycle_period <= osp_pkg::CYCLE_PERIOD_RST;
      end else if (wr_cycle) begin
         cycle_period <= WR_DATA_IN;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         command <= osp_pkg::COMMAND_RST;
      end else if (wr_cmd) begin
         command <= WR_DATA_IN[15:0];
      end
   end

   // elapsed-time trackers in ns
   logic [31:0] since_start;
   logic [31:0] since_s0;
   logic [31:0] since_s1;
   logic        local_tick;
   logic        cycle_start;
   logic        cycle_seen;
   logic        s0_seen;
   logic [31:0] interval;
   logic [31:0] s0_delay;
   logic [31:0] s1_delay;
   logic [31:0] s0_s1_gap;

   assign interval  = sat_add(since_start);
   assign s0_delay  = sat_add(since_s0);
   assign s1_delay  = sat_add(since_s1);
   assign s0_s1_gap = s0_delay;

   // local timer runs on the cycle period in free run
   assign local_tick = (interval >= cycle_period);

   // cycle source follows mode, DC overrides
   always_comb begin
      if (dc_mode) begin
         cycle_start = ev_s0;
      end else if (sync_mode == osp_pkg::MODE_FREE_RUN) begin
         cycle_start = local_tick;
      end else begin
         cycle_start = ev_sm2;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         since_start <= '0;
      end else if (cycle_start) begin
         since_start <= '0;
      end else begin
         since_start <= interval;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         since_s0 <= '0;
         since_s1 <= '0;
      end else begin
         since_s0 <= ev_s0 ? '0 : s0_delay;
         since_s1 <= ev_s1 ? '0 : s1_delay;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cycle_seen <= 1'b0;
         s0_seen    <= 1'b0;
      end else begin
         cycle_seen <= cycle_seen | cycle_start;
         s0_seen    <= s0_seen | ev_s0;
      end
   end

   // cycle busy until outputs are driven; a new start wins
   logic busy;
   logic sm2_since_s0;

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         busy <= 1'b0;
      end else if (cycle_start) begin
         busy <= 1'b1;
      end else if (ev_done) begin
         busy <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sm2_since_s0 <= 1'b0;
      end else if (ev_sm2) begin
         sm2_since_s0 <= 1'b1;
      end else if (ev_s0) begin
         sm2_since_s0 <= 1'b0;
      end
   end

   // measured timing entries
   logic [31:0] sync0_delay;
   logic [31:0] sync1_delay;
   logic [31:0] min_cycle;
   logic [31:0] min_gap;

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sync0_delay <= osp_pkg::SYNC0_DELAY_RST;
      end else if (meas_start) begin
         sync0_delay <= '0;
      end else if (measuring && dc_mode && ev_done && s0_seen) begin
         sync0_delay <= max32(sync0_delay, s0_delay);
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sync1_delay <= osp_pkg::SYNC1_DELAY_RST;
      end else if (meas_start) begin
         sync1_delay <= '0;
      end else if (measuring && dc_mode && ev_done && s0_seen) begin
         sync1_delay <= max32(sync1_delay, s1_delay);
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         min_cycle <= osp_pkg::MIN_CYCLE_RST;
      end else if (meas_start) begin
         min_cycle <= '0;
      end else if (measuring && cycle_start && cycle_seen) begin
         min_cycle <= max32(min_cycle, interval);
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         min_gap <= osp_pkg::MIN_GAP_RST;
      end else if (meas_start) begin
         min_gap <= '0;
      end else if (measuring && dc_mode && ev_s1 && s0_seen) begin
         min_gap <= max32(min_gap, s0_s1_gap);
      end
   end

   // event counters
   logic [osp_pkg::CNT_NUM-1:0] ev_inc;
   logic [osp_pkg::CNT_W-1:0]   ev_count [osp_pkg::CNT_NUM];

   // sync0 with no sm event since the last one
   assign ev_inc[osp_pkg::CNT_MISSED] = dc_mode && op_state && ev_s0 &&
                                        s0_seen && !sm2_since_s0;
   assign ev_inc[osp_pkg::CNT_OVERRUN] = op_state && cycle_start &&
      cycle_seen && ((busy && !ev_done) ||
                     (interval < osp_pkg::MIN_CYCLE_RST));
   assign ev_inc[osp_pkg::CNT_SHORT] = dc_mode && ev_s1 && s0_seen &&
                                       (s0_s1_gap < min_gap);

   generate
      for (genvar i = 0; i < osp_pkg::CNT_NUM; i++) begin : g_cnt
         osp_sat_cnt #(
            .W (osp_pkg::CNT_W)
         ) u_cnt (
            .clk_in    (CLK_IN),
            .rst_n_in  (RST_N_IN),
            .inc_in    (ev_inc[i]),
            .count_out (ev_count[i])
         );
      end
   endgenerate

   logic late_flag;

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         late_flag <= 1'b0;
      end else if (!dc_mode) begin
         late_flag <= 1'b0;
      end else if (ev_s0 && s0_seen) begin
         late_flag <= busy && !ev_done;
      end
   end

   // read port, data valid one cycle after the strobe only
   logic [31:0] next_rd_data;

   always_comb begin
      next_rd_data = '0;
      case (ADDR_IN)
         osp_pkg::IDX_ENTRY_COUNT:  next_rd_data = {24'h000000,
                                      osp_pkg::ENTRY_COUNT_VAL};
         osp_pkg::IDX_SYNC_MODE:    next_rd_data = {16'h0000, sync_mode};
         osp_pkg::IDX_CYCLE_PERIOD: next_rd_data = cycle_period;
         osp_pkg::IDX_SYNC0_DELAY:  next_rd_data = sync0_delay;
         osp_pkg::IDX_SUPPORTED:    next_rd_data = {16'h0000,
                                      osp_pkg::SUPPORTED_VAL};
         osp_pkg::IDX_MIN_CYCLE:    next_rd_data = min_cycle;
         osp_pkg::IDX_MIN_GAP:      next_rd_data = min_gap;
         osp_pkg::IDX_MIN_DELAY:    next_rd_data = osp_pkg::MIN_DELAY_VAL;
         osp_pkg::IDX_COMMAND:      next_rd_data = {16'h0000, command};
         osp_pkg::IDX_SYNC1_DELAY:  next_rd_data = sync1_delay;
         osp_pkg::IDX_MISSED:       next_rd_data = {16'h0000,
                                      ev_count[osp_pkg::CNT_MISSED]};
         osp_pkg::IDX_OVERRUN:      next_rd_data = {16'h0000,
                                      ev_count[osp_pkg::CNT_OVERRUN]};
         osp_pkg::IDX_SHORT:        next_rd_data = {16'h0000,
                                      ev_count[osp_pkg::CNT_SHORT]};
         osp_pkg::IDX_LATE:         next_rd_data = {31'h00000000,
                                      late_flag};
         default:                   next_rd_data = '0;
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         RD_DATA_OUT <= '0;
      end else begin
         RD_DATA_OUT <= RD_IN ? next_rd_data : '0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         CYCLE_START_OUT <= 1'b0;
         MEASURING_OUT   <= 1'b0;
      end else begin
         CYCLE_START_OUT <= cycle_start;
         MEASURING_OUT   <= measuring;
      end
   end

   // checks
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   sequence start_write_s;
      WR_IN && (ADDR_IN == osp_pkg::IDX_COMMAND) && !measuring &&
      (WR_DATA_IN[15:0] == osp_pkg::CMD_START);
   endsequence

   sequence sync0_pin_s;
      !SYNC0_IN ##1 SYNC0_IN [*3];
   endsequence

   mode_write_a: assert property (
      wr_mode |=> sync_mode == $past(WR_DATA_IN[15:0]))
      else $error("sync mode not stored");

   dc_cycle_a: assert property (
      (sync0_pin_s and DC_MODE_IN [*4]) |=> CYCLE_START_OUT)
      else $error("sync0 did not start a cycle in DC mode");

   caps_read_a: assert property (
      RD_IN && (ADDR_IN == osp_pkg::IDX_SUPPORTED)
      |=> RD_DATA_OUT == 32'h00008002 ##1 RD_DATA_OUT == 32'h00000000
          || $past(RD_IN))
      else $error("capability word wrong");

   cmd_run_a: assert property (
      wr_cmd |=> MEASURING_OUT == $past(measuring) ##1
      MEASURING_OUT == ($past(WR_DATA_IN[15:0], 2) == osp_pkg::CMD_START))
      else $error("measurement state does not follow command");

   meas_clear_a: assert property (
      start_write_s |=> (sync0_delay == 32'h0) && (sync1_delay == 32'h0)
                        && (min_cycle == 32'h0) && (min_gap == 32'h0))
      else $error("maxima not cleared on start");

   missed_count_a: assert property (
      ev_inc[osp_pkg::CNT_MISSED] && (ev_count[osp_pkg::CNT_MISSED] !=
         16'hFFFF)
      |=> ev_count[osp_pkg::CNT_MISSED] ==
          $past(ev_count[osp_pkg::CNT_MISSED]) + 16'h0001)
      else $error("missed event not counted");

   late_flag_a: assert property (
      dc_mode && ev_s0 && s0_seen && busy && !ev_done
      |=> late_flag ##1 (late_flag || !dc_mode || ev_s0))
      else $error("late output not flagged");

   entry_read_a: assert property (
      RD_IN && (ADDR_IN == osp_pkg::IDX_ENTRY_COUNT)
      |=> RD_DATA_OUT == 32'h00000020)
      else $error("entry count wrong");

   count_sat_a: assert property (
      ev_count[osp_pkg::CNT_OVERRUN] == 16'hFFFF
      |=> ev_count[osp_pkg::CNT_OVERRUN] == 16'hFFFF)
      else $error("overrun counter wrapped");
endmodule // osp_sync_monitor

// ===== osp_master_model.sv
// model of the fieldbus master that drives the cycle and sync pins
`timescale 1ns/1ps
module osp_master_model (
   input  wire logic                        clk_in,
   output logic [osp_pkg::PIN_NUM-1:0]      pins_out
);
   initial pins_out = '0;

   // each pin level held at least three clocks
   task automatic pulse(input int idx, input int high_cyc);
      pins_out[idx] <= 1'b1;
      repeat ((high_cyc < 3) ? 3 : high_cyc) @(posedge clk_in);
      pins_out[idx] <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic level(input int idx, input logic val);
      pins_out[idx] <= val;
      repeat (4) @(posedge clk_in);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask
endmodule // osp_master_model

// ===== osp_sync_monitor_tb_top.sv
// self-checking bench for the output synchronisation parameter block
`timescale 1ns/1ps
module osp_sync_monitor_tb_top;
   logic                        clk;
   logic                        rst_n;
   logic [7:0]                  addr;
   logic [31:0]                 wr_data;
   logic                        wr;
   logic                        rd;
   logic [31:0]                 rd_data;
   logic [osp_pkg::PIN_NUM-1:0] pins;
   logic                        cyc_start;
   logic                        measuring;
   int                          error_cnt;
   int                          n_compared;
   int                          starts = 0;
   int                          s0;
   int                          k;
   logic [31:0]                 v;
   logic [31:0]                 g;
   localparam logic [7:0]  idx_tab [18] = '{8'h00, 8'h01, 8'h02, 8'h03,
      8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0D,
      8'h20, 8'h0A, 8'h0E, 8'h1F, 8'hFF};
   localparam logic [31:0] def_tab [18] = '{32'h20, 32'h1, 32'hF4240,
      32'h384, 32'h8002, 32'h2710, 32'h0, 32'h384, 32'h0, 32'h384,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   osp_sync_monitor osp_sync_monitor_inst (
      .CLK_IN          (clk),
      .RST_N_IN        (rst_n),
      .ADDR_IN         (addr),
      .WR_DATA_IN      (wr_data),
      .WR_IN           (wr),
      .RD_IN           (rd),
      .RD_DATA_OUT     (rd_data),
      .SM2_EVENT_IN    (pins[osp_pkg::PIN_SM2]),
      .SYNC0_IN        (pins[osp_pkg::PIN_S0]),
      .SYNC1_IN        (pins[osp_pkg::PIN_S1]),
      .OUT_DONE_IN     (pins[osp_pkg::PIN_DONE]),
      .DC_MODE_IN      (pins[osp_pkg::PIN_DC]),
      .OPERATIONAL_IN  (pins[osp_pkg::PIN_OP]),
      .CYCLE_START_OUT (cyc_start),
      .MEASURING_OUT   (measuring)
   );

   osp_master_model osp_master_model_inst (
      .clk_in   (clk),
      .pins_out (pins)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // one count per high cycle, so a stretched pulse shows up
   always @(negedge clk) begin
      if (cyc_start === 1'b1) starts <= starts + 1;
   end

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cmp32(input string what, input logic [31:0] e,
                        input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic cmp1(input string what, input logic e, input logic s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s expected %b seen %b", what, e, s);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      wr      <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   // data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rd_data;
      @(negedge clk);
      cmp32("read data idle", 32'h0, rd_data);
      @(posedge clk);
   endtask

   task automatic wait_start(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cyc_start !== 1'b1 && n < 2000);
      @(posedge clk);
      if (n >= 2000) begin
         error_cnt++;
         wrap_up();
      end
   endtask

   task automatic dc_cycle(input int gap, input logic done, input logic sm2);
      osp_master_model_inst.pulse(osp_pkg::PIN_S0, 3);
      if (sm2) osp_master_model_inst.pulse(osp_pkg::PIN_SM2, 5);
      if (done) osp_master_model_inst.pulse(osp_pkg::PIN_DONE, 3);
      osp_master_model_inst.idle(gap);
   endtask

   task automatic sync_pair(input int s1_gap);
      osp_master_model_inst.pulse(osp_pkg::PIN_S0, 3);
      osp_master_model_inst.idle(s1_gap);
      osp_master_model_inst.pulse(osp_pkg::PIN_S1, 3);
      osp_master_model_inst.pulse(osp_pkg::PIN_DONE, 3);
      osp_master_model_inst.idle(40);
   endtask

   task automatic check_defaults();
      logic [31:0] d;
      for (int i = 0; i < 18; i++) begin
         reg_rd(idx_tab[i], d);
         cmp32("register default", def_tab[i], d);
      end
   endtask

   task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      reg_rd(a, d);
      cmp32("register value", e, d);
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end

   initial begin
      void'($urandom(97975));
      rst_n      = 1'b0;
      addr       = 8'h00;
      wr_data    = 32'h0;
      wr         = 1'b0;
      rd         = 1'b0;
      error_cnt  = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check_defaults();
      // read-only and unmapped places ignore writes
      for (int i = 0; i < 18; i++) begin
         if (!(idx_tab[i] inside {8'h01, 8'h02, 8'h08}))
            reg_wr(idx_tab[i], $urandom());
      end
      check_defaults();
      reg_wr(osp_pkg::IDX_SYNC_MODE, {16'($urandom()), 16'h0000});
      check_reg(osp_pkg::IDX_SYNC_MODE, 32'h0);
      reg_wr(osp_pkg::IDX_SYNC_MODE, 32'h1);
      check_reg(osp_pkg::IDX_SYNC_MODE, 32'h1);
      g = $urandom();
      reg_wr(osp_pkg::IDX_CYCLE_PERIOD, g);
      check_reg(osp_pkg::IDX_CYCLE_PERIOD, g);
      // second reset in mid-run clears everything
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check_defaults();
      osp_master_model_inst.level(osp_pkg::PIN_DC, 1'b1);
      osp_master_model_inst.level(osp_pkg::PIN_OP, 1'b1);
      s0 = starts;
      dc_cycle(100, 1'b1, 1'b1);
      dc_cycle(100, 1'b1, 1'b1);
      dc_cycle(100, 1'b0, 1'b0);
      dc_cycle(100, 1'b1, 1'b1);
      check_reg(osp_pkg::IDX_MISSED, 32'h1);
      check_reg(osp_pkg::IDX_OVERRUN, 32'h1);
      check_reg(osp_pkg::IDX_LATE, 32'h1);
      dc_cycle(10, 1'b1, 1'b1);
      dc_cycle(100, 1'b1, 1'b1);
      check_reg(osp_pkg::IDX_MISSED, 32'h1);
      check_reg(osp_pkg::IDX_OVERRUN, 32'h2);
      check_reg(osp_pkg::IDX_LATE, 32'h0);
      osp_master_model_inst.level(osp_pkg::PIN_OP, 1'b0);
      dc_cycle(100, 1'b0, 1'b0);
      dc_cycle(10, 1'b1, 1'b0);
      check_reg(osp_pkg::IDX_MISSED, 32'h1);
      check_reg(osp_pkg::IDX_OVERRUN, 32'h2);
      check_reg(osp_pkg::IDX_LATE, 32'h1);
      cmp32("cycle starts", 32'(s0 + 8), 32'(starts));
      osp_master_model_inst.level(osp_pkg::PIN_DC, 1'b0);
      check_reg(osp_pkg::IDX_LATE, 32'h0);
      s0 = starts;
      osp_master_model_inst.pulse(osp_pkg::PIN_SM2, 3);
      osp_master_model_inst.idle(6);
      cmp32("sm event start", 32'(s0 + 1), 32'(starts));
      g = 32'(100 * (20 + $urandom_range(20)));
      reg_wr(osp_pkg::IDX_CYCLE_PERIOD, g);
      reg_wr(osp_pkg::IDX_SYNC_MODE, 32'h0);
      wait_start(k);
      wait_start(k);
      cmp32("free run period", g / 100, 32'(k));
      reg_wr(osp_pkg::IDX_SYNC_MODE, 32'h1);
      osp_master_model_inst.level(osp_pkg::PIN_DC, 1'b1);
      reg_wr(osp_pkg::IDX_COMMAND, 32'h1);
      @(negedge clk);
      cmp1("measuring on", 1'b1, measuring);
      @(posedge clk);
      for (int i = 3; i < 10; i++) begin
         if (i != 4 && i != 7) check_reg(8'(i), 32'(i == 8));
      end
      sync_pair(20);
      reg_rd(osp_pkg::IDX_MIN_GAP, g);
      cmp1("gap in ns", 1'b1, g >= 32'h9C4 && g <= 32'hA8C);
      reg_rd(osp_pkg::IDX_SYNC0_DELAY, v);
      cmp1("sync0 delay", 1'b1, v >= 32'hC1C && v <= 32'hCE4);
      reg_rd(osp_pkg::IDX_SYNC1_DELAY, v);
      cmp1("sync1 delay", 1'b1, v >= 32'h1F4 && v <= 32'h2BC);
      sync_pair(5);
      check_reg(osp_pkg::IDX_MIN_GAP, g);
      reg_wr(osp_pkg::IDX_COMMAND, 32'h0);
      @(negedge clk);
      cmp1("measuring off", 1'b0, measuring);
      @(posedge clk);
      sync_pair(5);
      check_reg(osp_pkg::IDX_MIN_GAP, g);
      check_reg(osp_pkg::IDX_SHORT, 32'h2);
      wrap_up();
   end
endmodule // osp_sync_monitor_tb_top
